// ==== hw/pci_pin_change.sv ====
/*
 Pin change interrupt unit: two 8-bit ports with per-pin rising/falling enables,
 sticky flags, a summary flag, global enable, wake request and AXI4-Lite slave.
 Assumes pins are asynchronous to aclk and software holds one access at a time.
*/
// What this block does
// - Rising detector per pin, gated by enable bit
// - Falling detector per pin, gated by enable bit
// - Both enables set detect both edge polarities
// - Detection continues while global enable clear
// - Enabled edge sets flag; interrupt if enabled
// - Summary flag is OR of all flags
// - Writing zero to a flag clears it
// - Edge during flag write leaves flag set
// - Wake request in sleep only when enabled
// - Sleep edges recorded before first instruction
// - Port A rising bits 7:6 zero, 5:0 RW
// - Any combination of implemented pins may be a source
`timescale 1ns/1ps
`default_nettype none
`include "pci_map.svh"

module pci_pin_change #(
    parameter int PORTS = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] porta_pins,
    input wire logic [7:0] portb_pins,
    input wire logic core_sleeping,
    output logic irq,
    output logic pin_change_irq,
    output logic wake_req,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Map, masks and pin vectors are laid out for exactly two 8-bit ports
    if (PORTS != 2) begin : g_ports_check
        $error("pci_pin_change supports exactly two ports");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [15:0] pin_meta_r;
    logic [15:0] pin_sync_r;
    logic [15:0] pin_prev_r;
    logic [15:0] rise_en_r;
    logic [15:0] fall_en_r;
    logic [15:0] flag_r;
    logic [15:0] impl_mask;
    logic [15:0] edge_hit;
    logic pin_change_int_enable_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic summary;

    assign impl_mask = {`PCI_PORTB_MASK, `PCI_PORTA_MASK};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
            pin_prev_r <= 16'h0000;
        end else begin
            pin_meta_r <= {portb_pins, porta_pins};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // The previous-sample register is cleared in reset, so a pin held high is
    // seen as one rising edge after release; enables reset to zero hide it.
    assign edge_hit = impl_mask & ((rise_en_r & pin_sync_r & ~pin_prev_r)
                                 | (fall_en_r & ~pin_sync_r & pin_prev_r));

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data may arrive in either order

    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic wr_lane0;
    pci_pkg::pci_byte_t wbyte;
    logic wr_ok;
    logic rd_ok;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && wstrb_r[0];
    assign wbyte = wdata_r[7:0];
    assign s_axi_arready = !s_axi_rvalid;

    // Each half is parked until the other arrives, so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
    end

    // A write with lane 0 off is acknowledged but changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pci_pkg::PCI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? pci_pkg::PCI_RESP_OKAY : pci_pkg::PCI_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        case ({awaddr_r[11:2], 2'b00})
            `PCI_PORTA_RISE_OFF, `PCI_PORTA_FALL_OFF, `PCI_PORTA_FLAG_OFF,
            `PCI_PORTB_RISE_OFF, `PCI_PORTB_FALL_OFF, `PCI_PORTB_FLAG_OFF,
            `PCI_GLOBAL_EN_OFF, `PCI_SUMMARY_OFF, `PCI_STAT_OFF, `PCI_MASK_OFF: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [11:0] wr_addr;
    assign wr_addr = {awaddr_r[11:2], 2'b00};

    // Unimplemented pins are masked here so they can never raise a flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_en_r <= {`PCI_REG_RESET, `PCI_REG_RESET};
        end else if (wr_lane0 && wr_addr == `PCI_PORTA_RISE_OFF) begin
            rise_en_r[7:0] <= wbyte & `PCI_PORTA_MASK;
        end else if (wr_lane0 && wr_addr == `PCI_PORTB_RISE_OFF) begin
            rise_en_r[15:8] <= wbyte & `PCI_PORTB_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fall_en_r <= {`PCI_REG_RESET, `PCI_REG_RESET};
        end else if (wr_lane0 && wr_addr == `PCI_PORTA_FALL_OFF) begin
            fall_en_r[7:0] <= wbyte & `PCI_PORTA_MASK;
        end else if (wr_lane0 && wr_addr == `PCI_PORTB_FALL_OFF) begin
            fall_en_r[15:8] <= wbyte & `PCI_PORTB_MASK;
        end
    end

    // Clearing the enable only masks the request; edges are still flagged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_change_int_enable_r <= 1'b0;
        end else if (wr_lane0 && wr_addr == `PCI_GLOBAL_EN_OFF) begin
            pin_change_int_enable_r <= wbyte[`PCI_ENABLE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= 2'b00;
        end else if (wr_lane0 && wr_addr == `PCI_MASK_OFF) begin
            mask_r <= wbyte[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: a new edge always beats a software clear

    logic [15:0] flag_wr_sel;
    logic [15:0] flag_wr_val;

    always_comb begin
        flag_wr_sel = 16'h0000;
        flag_wr_val = {wbyte, wbyte};
        if (wr_lane0 && {awaddr_r[11:2], 2'b00} == `PCI_PORTA_FLAG_OFF) begin
            flag_wr_sel = 16'h00ff;
        end else if (wr_lane0 && {awaddr_r[11:2], 2'b00} == `PCI_PORTB_FLAG_OFF) begin
            flag_wr_sel = 16'hff00;
        end
    end

    // Flags keep recording edges while the core sleeps, so they are current at wake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 16'h0000;
        end else begin
            flag_r <= impl_mask & (((flag_r & ~flag_wr_sel) | (flag_wr_val & flag_wr_sel))
                                   | edge_hit);
        end
    end

    assign summary = |flag_r;
    assign pin_change_irq = summary && pin_change_int_enable_r;
    assign wake_req = core_sleeping && pin_change_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Block interrupt status: bit0 edge seen, bit1 summary raised

    logic [1:0] stat_set;
    logic [1:0] stat_clr;

    assign stat_set = {summary, |edge_hit};
    assign stat_clr = (wr_lane0 && {awaddr_r[11:2], 2'b00} == `PCI_STAT_OFF) ? wbyte[1:0] : 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 2'b00;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | stat_set;
        end
    end

    assign irq = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    pci_pkg::pci_byte_t rbyte;

    always_comb begin
        rd_ok = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            `PCI_PORTA_RISE_OFF: rbyte = rise_en_r[7:0];
            `PCI_PORTA_FALL_OFF: rbyte = fall_en_r[7:0];
            `PCI_PORTA_FLAG_OFF: rbyte = flag_r[7:0];
            `PCI_PORTB_RISE_OFF: rbyte = rise_en_r[15:8];
            `PCI_PORTB_FALL_OFF: rbyte = fall_en_r[15:8];
            `PCI_PORTB_FLAG_OFF: rbyte = flag_r[15:8];
            `PCI_GLOBAL_EN_OFF: rbyte = {7'h00, pin_change_int_enable_r};
            `PCI_SUMMARY_OFF: rbyte = {7'h00, summary};
            `PCI_STAT_OFF: rbyte = {6'h00, stat_r};
            `PCI_MASK_OFF: rbyte = {6'h00, mask_r};
            default: begin
                rbyte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Data is captured with the address, so it cannot drift while rvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pci_pkg::PCI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {24'h000000, rbyte};
            s_axi_rresp <= rd_ok ? pci_pkg::PCI_RESP_OKAY : pci_pkg::PCI_RESP_SLVERR;
        end
    end

endmodule : pci_pin_change
`default_nettype wire

// ==== hw/pci_map.svh ====
/*
 Register offsets, field positions, reset values and pin masks for the pin change unit.
 Assumes inclusion by bare name from the design file.
*/
`ifndef PCI_MAP_SVH
`define PCI_MAP_SVH
`define PCI_PORTA_RISE_OFF 12'h000
`define PCI_PORTA_FALL_OFF 12'h004
`define PCI_PORTA_FLAG_OFF 12'h008
`define PCI_PORTB_RISE_OFF 12'h00c
`define PCI_PORTB_FALL_OFF 12'h010
`define PCI_PORTB_FLAG_OFF 12'h014
`define PCI_GLOBAL_EN_OFF 12'h018
`define PCI_SUMMARY_OFF 12'h01c
`define PCI_STAT_OFF 12'h020
`define PCI_MASK_OFF 12'h024
`define PCI_PORTA_MASK 8'h3f
`define PCI_PORTB_MASK 8'hf0
`define PCI_ENABLE_BIT 0
`define PCI_SUMMARY_BIT 0
`define PCI_REG_RESET 8'h00
`endif

// ==== hw/pci_pkg.sv ====
/*
 Types shared by the pin change unit.
 Assumes nothing of its surroundings.
*/
package pci_pkg;
    typedef logic [7:0] pci_byte_t;
    typedef enum logic [1:0] {
        PCI_RESP_OKAY = 2'b00,
        PCI_RESP_SLVERR = 2'b10
    } pci_resp_t;
endpackage : pci_pkg

// ==== testbench/pci_monitor.sv ====
/* Port checker for the pin change unit.
 Assumes a bind onto pci_pin_change. */
`timescale 1ns/1ps
`default_nettype none
module pci_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_sleeping,
    input wire logic pin_change_irq,
    input wire logic wake_req,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wake_gate_a: assert property (wake_req == (core_sleeping && pin_change_irq)) else $error("wake");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid");
    rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rdone");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bdone");
    cover property (wake_req);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (pin_change_irq && !core_sleeping);
endmodule : pci_monitor
bind pci_pin_change pci_monitor i_mon (.aclk, .aresetn, .core_sleeping, .pin_change_irq, .wake_req,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// ==== testbench/pci_pin_model.sv ====
/* Far-side model: port pins and core sleep state.
 Assumes the bench sets levels; port B stays low. */
`timescale 1ns/1ps
`default_nettype none
module pci_pin_model (
    input wire logic aclk,
    input wire logic [7:0] a_set,
    input wire logic sleep_set,
    output logic [7:0] porta_pins,
    output logic [7:0] portb_pins,
    output logic core_sleeping
);
    // Port B has no stimulus in this bench
    assign portb_pins = 8'h00;
    // Levels move just after an edge so each step is one clean change
    always @(posedge aclk) begin
        porta_pins <= a_set;
        core_sleeping <= sleep_set;
    end
endmodule : pci_pin_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Bench: register rows in a loop, then edge, sleep and interrupt cases.
 Assumes the pin model and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, sleep_set = 1'b0, core_sleeping, irq, pin_change_irq, wake_req;
    logic [7:0] a_set = 8'h00, porta_pins, portb_pins;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [3:0] s_axi_wstrb = 4'hf;
    int failures = 0, samples_checked = 0;
    // Row: address, expected read after writing 0xff, expected response
    logic [21:0] rows [6] = '{{12'h000, 8'h3f, 2'h0}, {12'h004, 8'h3f, 2'h0}, {12'h00c, 8'hf0, 2'h0},
        {12'h010, 8'hf0, 2'h0}, {12'h018, 8'h01, 2'h0}, {12'hffc, 8'h00, 2'h2}};
    always #2.5 aclk = ~aclk;
    pci_pin_model i_pins (.aclk, .a_set, .sleep_set, .porta_pins, .portb_pins, .core_sleeping);
    pci_pin_change i_dut (.aclk, .aresetn, .porta_pins, .portb_pins, .core_sleeping, .irq, .pin_change_irq,
        .wake_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim;
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        wr_resp = s_axi_bresp;
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_resp = s_axi_rresp;
        chk(s_axi_rdata, e);
    endtask : rd
    // Pin changes need two sync stages plus the compare stage
    task settle;
        repeat (6) @(posedge aclk);
    endtask : settle
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h008, 32'h0);
        chk({irq, pin_change_irq, wake_req}, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i][21:10], 32'hff);
            rd(rows[i][21:10], {24'h0, rows[i][9:2]});
            chk(rd_resp, rows[i][1:0]);
            chk(wr_resp, rows[i][1:0]);
        end
        s_axi_wstrb <= 4'h0;
        wr(12'h018, 32'h00);
        s_axi_wstrb <= 4'hf;
        rd(12'h018, 32'h01);
        wr(12'h000, 32'h01);
        wr(12'h004, 32'h03);
        wr(12'h018, 32'h00);
        a_set <= 8'h03;
        settle;
        rd(12'h008, 32'h01);
        chk(pin_change_irq, 1'b0);
        rd(12'h01c, 32'h01);
        wr(12'h008, 32'h00);
        rd(12'h008, 32'h00);
        a_set <= 8'h00;
        settle;
        rd(12'h008, 32'h03);
        wr(12'h018, 32'h01);
        chk(pin_change_irq, 1'b1);
        sleep_set <= 1'b1;
        settle;
        chk(wake_req, 1'b1);
        wr(12'h018, 32'h00);
        chk(wake_req, 1'b0);
        sleep_set <= 1'b0;
        wr(12'h008, 32'h00);
        wr(12'h020, 32'h03);
        wr(12'h024, 32'h00);
        a_set <= 8'h01;
        settle;
        chk(irq, 1'b0);
        rd(12'h020, 32'h03);
        wr(12'h024, 32'h01);
        chk(irq, 1'b1);
        wr(12'h020, 32'h01);
        chk(irq, 1'b0);
        // A falling edge lands in the very cycle that the zero is written
        wr(12'h008, 32'h00);
        a_set <= 8'h00;
        @(posedge aclk);
        wr(12'h008, 32'h00);
        rd(12'h008, 32'h01);
        // Reset in mid-run returns every enable and flag to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h000, 32'h00);
        rd(12'h008, 32'h00);
        chk({irq, pin_change_irq, wake_req}, 32'h0);
        // Edge while asleep is flagged by the time the core wakes
        wr(12'h000, 32'h04);
        wr(12'h018, 32'h01);
        sleep_set <= 1'b1;
        settle;
        chk(wake_req, 1'b0);
        a_set <= 8'h04;
        settle;
        chk(wake_req, 1'b1);
        rd(12'h008, 32'h04);
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
